//--- asm_ctrl.sv
/*
 Auto-sleep mode controller: inactivity count and the two system control
 registers, standby/wake/sleep state, effective rate and oversampling.
 Assumes a serial front end on the same clock that presents byte accesses
 on the register port and follows the burst address it is given.
*/
module asm_ctrl
   import asm_pkg::*;
#(
   parameter int UNIT_CYCLES = ASM_UNIT_CYCLES
) (
   input wire logic sys_clk_in,
   input wire logic nrst_in,
   input wire logic [7:0] reg_addr_in,
   input wire logic [7:0] reg_wdata_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   input wire asm_events_t events_in,
   input wire asm_events_t fn_int_en_in,
   input wire asm_events_t fn_wake_sel_in,
   input wire logic sleep_wake_int_en_in,
   output logic [7:0] reg_rdata_out,
   output logic [7:0] burst_addr_out,
   output logic serial_reset_out,
   output logic device_reset_out,
   output asm_mode_t mode_out,
   output logic [2:0] eff_rate_out,
   output logic [1:0] eff_oversample_out,
   output logic [10:0] osr_out,
   output logic low_noise_out,
   output logic fast_read_out,
   output logic selfcheck_out,
   output logic sleep_wake_irq_out
);

   if (UNIT_CYCLES < 1 || UNIT_CYCLES > 24'hFFFFFF) begin : g_chk
      $error("UNIT_CYCLES out of range");
   end

   localparam logic [23:0] UNIT_LAST = 24'(UNIT_CYCLES - 1);

   function automatic logic [10:0] osr_of(input logic [2:0] rate,
                                          input logic [1:0] os);
      logic [10:0] r;
      r = 11'h002;
      case (os)
         ASM_OS_NORMAL: begin
            case (rate)
               3'h0: r = 11'h002;
               3'h5: r = 11'h010;
               3'h6: r = 11'h020;
               3'h7: r = 11'h080;
               default: r = 11'h004;
            endcase
         end
         ASM_OS_LNLP: begin
            case (rate)
               3'h0: r = 11'h002;
               3'h6: r = 11'h008;
               3'h7: r = 11'h020;
               default: r = 11'h004;
            endcase
         end
         ASM_OS_HIRES: begin
            // Ratio jumps fourfold below 50 Hz, not a plain doubling
            case (rate)
               3'h5: r = 11'h080;
               3'h6: r = 11'h100;
               3'h7: r = 11'h400;
               default: r = 11'(11'h002 << rate);
            endcase
         end
         ASM_OS_LP: begin
            case (rate)
               3'h6: r = 11'h004;
               3'h7: r = 11'h010;
               default: r = 11'h002;
            endcase
         end
         default: r = 11'h002;
      endcase
      return r;
   endfunction

   function automatic logic [7:0] next_addr(input logic [7:0] a,
                                            input logic fast);
      logic [7:0] n;
      n = a + 8'h01;
      if (fast && a >= ASM_ADDR_DATA_FIRST && a < ASM_ADDR_DATA_LAST &&
          a[0]) begin
         n = a + 8'h02;
      end
      return n;
   endfunction

   logic [7:0] inact_cnt_r, inact_cnt_nxt;
   asm_ctrl1_t ctrl1_r, ctrl1_nxt;
   asm_ctrl2_t ctrl2_r, ctrl2_nxt;
   asm_mode_t mode_r, mode_nxt;
   logic [23:0] unit_cnt_r, unit_cnt_nxt;
   logic half_r, half_nxt;
   logic [7:0] timer_r, timer_nxt;
   logic booting_r, booting_nxt;
   logic [2:0] boot_cnt_r, boot_cnt_nxt;
   logic [7:0] rdata_r, rdata_nxt;
   logic [7:0] burst_r, burst_nxt;
   logic serial_rst_r, serial_rst_nxt;
   logic irq_r, irq_nxt;
   logic [2:0] rate_r, rate_nxt;
   logic [1:0] os_r, os_nxt;
   logic [10:0] osr_r, osr_nxt;
   logic soft_wr, wr_ok, restart, wake_hit, unit_tick, step, expired;

   // only the four function events are inputs at all
   assign restart = |(events_in & fn_int_en_in);
   assign wake_hit = |(events_in & fn_int_en_in & fn_wake_sel_in);
   assign wr_ok = reg_wr_in && !booting_r;
   assign soft_wr = wr_ok && reg_addr_in == ASM_ADDR_CTRL2 &&
                    reg_wdata_in[ASM_CTRL2_RST_BIT];
   assign unit_tick = unit_cnt_r == UNIT_LAST;
   // doubled unit at the slowest wake rate
   assign step = unit_tick &&
                 (ctrl1_r.output_rate_sel != ASM_RATE_1P56 || half_r);
   assign expired = timer_r >= inact_cnt_r;

   always_comb begin
      inact_cnt_nxt = inact_cnt_r;
      ctrl1_nxt = ctrl1_r;
      ctrl2_nxt = ctrl2_r;
      booting_nxt = booting_r;
      boot_cnt_nxt = boot_cnt_r;
      serial_rst_nxt = 1'b0;
      if (booting_r) begin
         boot_cnt_nxt = boot_cnt_r - 3'h1;
         if (boot_cnt_r == 3'h0) begin
            booting_nxt = 1'b0;
            ctrl2_nxt.soft_reset = 1'b0;
         end
      end
      if (soft_wr) begin
         inact_cnt_nxt = ASM_INACT_RST;
         ctrl1_nxt = ASM_CTRL1_RST;
         ctrl2_nxt = ASM_CTRL2_RST;
         ctrl2_nxt.soft_reset = 1'b1;
         booting_nxt = 1'b1;
         boot_cnt_nxt = ASM_BOOT_CYCLES - 3'h1;
         serial_rst_nxt = 1'b1;
      end else if (wr_ok) begin
         case (reg_addr_in)
            ASM_ADDR_INACT: inact_cnt_nxt = reg_wdata_in;
            ASM_ADDR_CTRL1: begin
               if (!ctrl1_r.active) begin
                  ctrl1_nxt = reg_wdata_in;
               end else begin
                  ctrl1_nxt.active = reg_wdata_in[ASM_CTRL1_ACTIVE_BIT];
               end
            end
            ASM_ADDR_CTRL2: begin
               ctrl2_nxt = reg_wdata_in;
               ctrl2_nxt.soft_reset = 1'b0;
               ctrl2_nxt.spare = 1'b0;
            end
            default: ;
         endcase
      end
   end

   always_ff @(posedge sys_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         inact_cnt_r <= ASM_INACT_RST;
         ctrl1_r <= ASM_CTRL1_RST;
         ctrl2_r <= ASM_CTRL2_RST;
         booting_r <= 1'b0;
         boot_cnt_r <= 3'h0;
         serial_rst_r <= 1'b0;
      end else begin
         inact_cnt_r <= inact_cnt_nxt;
         ctrl1_r <= ctrl1_nxt;
         ctrl2_r <= ctrl2_nxt;
         booting_r <= booting_nxt;
         boot_cnt_r <= boot_cnt_nxt;
         serial_rst_r <= serial_rst_nxt;
      end
   end

   // Read data and burst address
   always_comb begin
      rdata_nxt = rdata_r;
      burst_nxt = burst_r;
      if (soft_wr) begin
         burst_nxt = 8'h00;
      end else if (reg_rd_in) begin
         burst_nxt = next_addr(reg_addr_in, ctrl1_r.fast_read_en);
         case (reg_addr_in)
            ASM_ADDR_INACT: rdata_nxt = inact_cnt_r;
            ASM_ADDR_CTRL1: rdata_nxt = ctrl1_r;
            ASM_ADDR_CTRL2: rdata_nxt = ctrl2_r & 8'hBF;
            default: rdata_nxt = 8'h00;
         endcase
      end
   end

   always_ff @(posedge sys_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         rdata_r <= 8'h00;
         burst_r <= 8'h00;
      end else begin
         rdata_r <= rdata_nxt;
         burst_r <= burst_nxt;
      end
   end

   // Mode state and inactivity timer
   always_comb begin
      mode_nxt = mode_r;
      unit_cnt_nxt = unit_tick ? 24'h000000 : unit_cnt_r + 24'h000001;
      half_nxt = unit_tick ? !half_r : half_r;
      timer_nxt = (step && timer_r != 8'hFF) ? timer_r + 8'h01 : timer_r;
      irq_nxt = 1'b0;
      case (mode_r)
         ASM_STANDBY: begin
            if (ctrl1_r.active) begin
               mode_nxt = ASM_WAKE;
            end
         end
         ASM_WAKE: begin
            if (!ctrl1_r.active) begin
               mode_nxt = ASM_STANDBY;
            end else if (ctrl2_r.autosleep_en && expired && !restart) begin
               mode_nxt = ASM_SLEEP;
            end
         end
         ASM_SLEEP: begin
            if (!ctrl1_r.active) begin
               mode_nxt = ASM_STANDBY;
            end else if (!ctrl2_r.autosleep_en) begin
               mode_nxt = ASM_WAKE;
            end else if (wake_hit) begin
               mode_nxt = ASM_WAKE;
            end
         end
         default: mode_nxt = ASM_STANDBY;
      endcase
      // restart and fresh start on entering wake
      if (mode_r != ASM_WAKE || restart || mode_nxt != ASM_WAKE) begin
         unit_cnt_nxt = 24'h000000;
         half_nxt = 1'b0;
         timer_nxt = 8'h00;
      end
      if (soft_wr) begin
         mode_nxt = ASM_STANDBY;
      end
      if (sleep_wake_int_en_in &&
          ((mode_r == ASM_WAKE && mode_nxt == ASM_SLEEP) ||
           (mode_r == ASM_SLEEP && mode_nxt == ASM_WAKE))) begin
         irq_nxt = 1'b1;
      end
      if (mode_r == ASM_SLEEP) begin
         rate_nxt = {ASM_SLEEP_RATE_MSB, ctrl1_r.sleep_rate_sel};
         os_nxt = ctrl2_r.sleep_oversample_sel;
      end else begin
         rate_nxt = ctrl1_r.output_rate_sel;
         os_nxt = ctrl2_r.wake_oversample_sel;
      end
      osr_nxt = osr_of(rate_nxt, os_nxt);
   end

   always_ff @(posedge sys_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         mode_r <= ASM_STANDBY;
         unit_cnt_r <= 24'h000000;
         half_r <= 1'b0;
         timer_r <= 8'h00;
         irq_r <= 1'b0;
         rate_r <= ASM_RATE_800;
         os_r <= ASM_OS_NORMAL;
         osr_r <= 11'h002;
      end else begin
         mode_r <= mode_nxt;
         unit_cnt_r <= unit_cnt_nxt;
         half_r <= half_nxt;
         timer_r <= timer_nxt;
         irq_r <= irq_nxt;
         rate_r <= rate_nxt;
         os_r <= os_nxt;
         osr_r <= osr_nxt;
      end
   end

   assign reg_rdata_out = rdata_r;
   assign burst_addr_out = burst_r;
   assign serial_reset_out = serial_rst_r;
   // Device reset spans the whole boot
   assign device_reset_out = booting_r;
   assign mode_out = mode_r;
   assign eff_rate_out = rate_r;
   assign eff_oversample_out = os_r;
   assign osr_out = osr_r;
   // range limit to 4 g is the sensing path's job
   assign low_noise_out = ctrl1_r.low_noise_en;
   assign fast_read_out = ctrl1_r.fast_read_en;
   assign selfcheck_out = ctrl2_r.selfcheck_en;
   assign sleep_wake_irq_out = irq_r;

   default clocking cb @(posedge sys_clk_in); endclocking
   default disable iff (!nrst_in);

   AST_NO_SLEEP_WITHOUT_AUTO: assert property (
      (mode_r == ASM_SLEEP && !ctrl2_r.autosleep_en) |=>
      mode_r != ASM_SLEEP)
      else $error("sleep held without auto-sleep");

   AST_WAKE_CAUSE: assert property (
      ($past(mode_r) == ASM_SLEEP && mode_r == ASM_WAKE &&
       $past(ctrl1_r.active) && $past(ctrl2_r.autosleep_en)) |->
      $past(wake_hit))
      else $error("woke without a selected event");

   AST_IRQ_ON_SLEEP: assert property (
      (mode_r == ASM_WAKE && mode_nxt == ASM_SLEEP && sleep_wake_int_en_in)
      |=> irq_r && mode_r == ASM_SLEEP)
      else $error("no interrupt on sleep entry");

   AST_RESTART_TIMER: assert property (
      (mode_r == ASM_WAKE && restart) |=> timer_r == 8'h00)
      else $error("event did not restart timer");

   AST_SLEEP_RATE: assert property (
      mode_r == ASM_SLEEP |=>
      eff_rate_out == {ASM_SLEEP_RATE_MSB, $past(ctrl1_r.sleep_rate_sel)})
      else $error("sleep rate not applied");

   AST_ACTIVE_LOCK: assert property (
      (wr_ok && reg_addr_in == ASM_ADDR_CTRL1 && ctrl1_r.active) |=>
      ctrl1_r[7:1] == $past(ctrl1_r[7:1]))
      else $error("control one changed while active");

   AST_SOFT_RESET: assert property (
      soft_wr |=> (mode_r == ASM_STANDBY && inact_cnt_r == 8'h00 &&
                   ctrl1_r == ASM_CTRL1_RST && serial_reset_out))
      else $error("soft reset did not restore defaults");

   AST_BOOT_CLEAR: assert property (
      soft_wr |-> ##5 (!ctrl2_r.soft_reset && !booting_r))
      else $error("reset bit did not self-clear");

   AST_RST_READ_ZERO: assert property (
      (reg_rd_in && reg_addr_in == ASM_ADDR_CTRL2) |=> !reg_rdata_out[6])
      else $error("reset bit read as one");

   AST_STANDBY_EXIT: assert property (
      (!ctrl1_r.active && mode_r != ASM_STANDBY && !soft_wr) |=>
      mode_r == ASM_STANDBY)
      else $error("standby not entered");

endmodule

//--- asm_pkg.sv
/*
 Package for the auto-sleep mode controller: register offsets, field
 positions, reset values, rate codes, timing constants and carrier types.
 Assumes a single 40 MHz system clock.
*/
package asm_pkg;

   // Register offsets
   localparam logic [7:0] ASM_ADDR_INACT = 8'h29;
   localparam logic [7:0] ASM_ADDR_CTRL1 = 8'h2A;
   localparam logic [7:0] ASM_ADDR_CTRL2 = 8'h2B;
   // Acceleration data bytes walked by burst reads
   localparam logic [7:0] ASM_ADDR_DATA_FIRST = 8'h01;
   localparam logic [7:0] ASM_ADDR_DATA_LAST = 8'h06;

   // Reset values
   localparam logic [7:0] ASM_INACT_RST = 8'h00;
   localparam logic [7:0] ASM_CTRL1_RST = 8'h00;
   localparam logic [7:0] ASM_CTRL2_RST = 8'h00;

   // Field positions
   localparam int ASM_CTRL1_ACTIVE_BIT = 0;
   localparam int ASM_CTRL2_RST_BIT = 6;
   localparam int ASM_CTRL2_SPARE_BIT = 5;

   // Rate codes of the output rate field
   localparam logic [2:0] ASM_RATE_800 = 3'h0;
   localparam logic [2:0] ASM_RATE_1P56 = 3'h7;
   // Sleep rate codes map onto the top half of the rate codes
   localparam logic ASM_SLEEP_RATE_MSB = 1'h1;

   // Oversampling selector codes
   localparam logic [1:0] ASM_OS_NORMAL = 2'h0;
   localparam logic [1:0] ASM_OS_LNLP = 2'h1;
   localparam logic [1:0] ASM_OS_HIRES = 2'h2;
   localparam logic [1:0] ASM_OS_LP = 2'h3;

   // Timing
   localparam int ASM_CLK_HZ = 40_000_000;
   localparam int ASM_UNIT_MS = 320;
   localparam int ASM_UNIT_CYCLES = ASM_UNIT_MS * (ASM_CLK_HZ / 1000);
   localparam logic [2:0] ASM_BOOT_CYCLES = 3'h4;

   typedef enum logic [1:0] {ASM_STANDBY, ASM_WAKE, ASM_SLEEP} asm_mode_t;

   typedef struct packed {
      logic [1:0] sleep_rate_sel;
      logic [2:0] output_rate_sel;
      logic low_noise_en;
      logic fast_read_en;
      logic active;
   } asm_ctrl1_t;

   typedef struct packed {
      logic selfcheck_en;
      logic soft_reset;
      logic spare;
      logic [1:0] sleep_oversample_sel;
      logic autosleep_en;
      logic [1:0] wake_oversample_sel;
   } asm_ctrl2_t;

   typedef struct packed {
      logic transient_event;
      logic orientation_event;
      logic tap_event;
      logic freefall_motion_event;
   } asm_events_t;

endpackage

//--- asm_host_model.sv
/*
 Host side model: issues single byte reads and writes on the register port
 as the serial front end would. Assumes the caller starts a transfer after
 a falling edge and that read data settles one cycle after the read edge.
*/
module asm_host_model
   import asm_pkg::*;
(
   input wire logic sys_clk_in,
   input wire logic [7:0] reg_rdata_in,
   output logic [7:0] reg_addr_out,
   output logic [7:0] reg_wdata_out,
   output logic reg_wr_out,
   output logic reg_rd_out
);
   timeunit 1ns;
   timeprecision 1ps;

   initial begin
      reg_addr_out = 8'h00;
      reg_wdata_out = 8'h00;
      reg_wr_out = 1'b0;
      reg_rd_out = 1'b0;
   end

   task automatic xfer(input logic wr, input logic [7:0] a, d,
                       output logic [7:0] rd_data);
      @(posedge sys_clk_in);
      reg_addr_out <= a;
      reg_wdata_out <= d;
      reg_wr_out <= wr;
      reg_rd_out <= ~wr;
      @(posedge sys_clk_in);
      reg_wr_out <= 1'b0;
      reg_rd_out <= 1'b0;
      // Released lines flip so stale data never looks valid
      reg_addr_out <= ~a;
      reg_wdata_out <= ~d;
      @(negedge sys_clk_in);
      rd_data = reg_rdata_in;
   endtask
endmodule

//--- tb_top.sv
/*
 Testbench for the auto-sleep mode controller with a host model on the
 register port. Assumes a short inactivity unit so timeouts stay brief.
*/
module tb_top
   import asm_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   localparam int U = 4;
   logic sys_clk_in = 1'b0;
   logic nrst_in = 1'b0;
   asm_events_t ev = '0;
   asm_events_t ie = '0;
   asm_events_t ws = '0;
   logic swie = 1'b0;
   logic [7:0] ra, rwd, rdata, burst, rv;
   logic wr, rd, srst, drst, ln, fr, sc, irq;
   asm_mode_t mode;
   logic [2:0] rate;
   logic [1:0] os;
   logic [10:0] osr;
   int err_total = 0;
   int num_checks = 0;
   int irq_cnt = 0;
   int srst_cnt = 0;
   int drst_cnt = 0;
   int n, c, d;

   asm_host_model i_asm_host_model (.sys_clk_in(sys_clk_in),
      .reg_rdata_in(rdata), .reg_addr_out(ra), .reg_wdata_out(rwd),
      .reg_wr_out(wr), .reg_rd_out(rd));

   asm_ctrl #(.UNIT_CYCLES(U)) i_asm_ctrl (.sys_clk_in(sys_clk_in),
      .nrst_in(nrst_in), .reg_addr_in(ra), .reg_wdata_in(rwd),
      .reg_wr_in(wr), .reg_rd_in(rd), .events_in(ev), .fn_int_en_in(ie),
      .fn_wake_sel_in(ws), .sleep_wake_int_en_in(swie),
      .reg_rdata_out(rdata), .burst_addr_out(burst),
      .serial_reset_out(srst), .device_reset_out(drst), .mode_out(mode),
      .eff_rate_out(rate), .eff_oversample_out(os), .osr_out(osr),
      .low_noise_out(ln), .fast_read_out(fr), .selfcheck_out(sc),
      .sleep_wake_irq_out(irq));

   always #12.5 sys_clk_in = ~sys_clk_in;

   always @(posedge sys_clk_in) begin
      irq_cnt <= irq_cnt + int'(irq === 1'b1);
      srst_cnt <= srst_cnt + int'(srst === 1'b1);
      drst_cnt <= drst_cnt + int'(drst === 1'b1);
   end

   task automatic chk(input string what, input logic [10:0] seen, exp);
      num_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("FAIL %s expected %0h seen %0h", what, exp, seen);
      end
   endtask

   task automatic close_out();
      if (err_total == 0 && num_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   task automatic wr_reg(input logic [7:0] a, d);
      i_asm_host_model.xfer(1'b1, a, d, rv);
   endtask

   task automatic rd_chk(input string what, input logic [7:0] a, exp);
      i_asm_host_model.xfer(1'b0, a, 8'h00, rv);
      chk(what, {3'h0, rv}, {3'h0, exp});
   endtask

   task automatic tick(input int k);
      repeat (k) @(negedge sys_clk_in);
   endtask

   // Bounded wait; n holds the cycles spent
   task automatic wait_mode(input asm_mode_t m, input int lim);
      n = 0;
      while (mode !== m) begin
         @(negedge sys_clk_in);
         n++;
         if (n > lim) begin
            err_total++;
            $display("FAIL mode_wait expected %0d seen %0d", m, mode);
            close_out();
         end
      end
   endtask

   task automatic stim(input asm_events_t ie_v, ws_v, ev_v);
      @(posedge sys_clk_in);
      ie <= ie_v;
      ws <= ws_v;
      ev <= ev_v;
      @(posedge sys_clk_in);
      ev <= '0;
      tick(3);
   endtask

   task automatic sleep_time(input logic [7:0] cnt, input logic [1:0] sr,
                             input logic [2:0] r, input int units);
      wr_reg(ASM_ADDR_CTRL1, 8'h00);
      wr_reg(ASM_ADDR_INACT, cnt);
      wr_reg(ASM_ADDR_CTRL1, {sr, r, 3'h1});
      wait_mode(ASM_WAKE, 8);
      wait_mode(ASM_SLEEP, 400);
      chk("delay_lo", 11'(n >= units * U), 11'h1);
      chk("delay_hi", 11'(n <= units * U + U), 11'h1);
      tick(2);
      chk("sleep_rate", 11'(rate), {8'h0, 1'b1, sr});
   endtask

   initial begin
      #(25ns * 100000);
      err_total++;
      $display("FAIL timeout expected finish seen hang");
      close_out();
   end

   initial begin
      repeat (2) @(posedge sys_clk_in);
      nrst_in <= 1'b1;
      tick(1);
      rd_chk("inact_rst", ASM_ADDR_INACT, ASM_INACT_RST);
      rd_chk("ctrl1_rst", ASM_ADDR_CTRL1, ASM_CTRL1_RST);
      rd_chk("ctrl2_rst", ASM_ADDR_CTRL2, ASM_CTRL2_RST);
      rd_chk("unmapped", 8'h10, 8'h00);
      chk("mode_rst", 11'(mode), 11'(ASM_STANDBY));
      chk("osr_rst", osr, 11'h002);
      // Spare and reset bits read back as zero
      wr_reg(ASM_ADDR_CTRL2, 8'hB5);
      rd_chk("ctrl2_rd", ASM_ADDR_CTRL2, 8'h95);
      chk("selfcheck", 11'(sc), 11'h1);
      @(posedge sys_clk_in);
      swie <= 1'b1;
      sleep_time(8'h02, 2'h0, 3'h0, 2);
      sleep_time(8'h01, 2'h1, 3'h7, 2);
      sleep_time(8'h00, 2'h2, 3'h4, 0);
      sleep_time(8'h03, 2'h3, 3'h0, 3);
      chk("sleep_os", 11'(os), 11'h2);
      chk("osr_hires", osr, 11'd1024);
      for (int i = 0; i < 4; i++) begin
         wait_mode(ASM_SLEEP, 100);
         // Let the sleep entry pulse be counted first
         tick(2);
         c = irq_cnt;
         // missing select or enable keeps sleep
         stim(4'hF, ~(4'h8 >> i), 4'h8 >> i);
         stim(~(4'h8 >> i), 4'hF, 4'h8 >> i);
         chk("no_wake", 11'(mode), 11'(ASM_SLEEP));
         stim(4'hF, 4'h8 >> i, 4'h8 >> i);
         chk("wake", 11'(mode), 11'(ASM_WAKE));
         chk("irq_wake", 11'(irq_cnt - c), 11'h1);
         chk("wake_os", 11'(os), 11'h1);
         chk("osr_wake", osr, 11'h002);
      end
      wait_mode(ASM_SLEEP, 100);
      stim(4'hF, 4'hF, 4'h1);
      for (int i = 0; i < 5; i++) stim(4'hF, 4'h0, 4'h2);
      chk("restart", 11'(mode), 11'(ASM_WAKE));
      wr_reg(ASM_ADDR_CTRL1, 8'h3F);
      rd_chk("ctrl1_lock", ASM_ADDR_CTRL1, 8'hC1);
      chk("ln_lock", 11'(ln), 11'h0);
      wr_reg(ASM_ADDR_CTRL1, 8'h3E);
      rd_chk("ctrl1_stby", ASM_ADDR_CTRL1, 8'hC0);
      tick(2);
      chk("stby", 11'(mode), 11'(ASM_STANDBY));
      wr_reg(ASM_ADDR_CTRL1, 8'h06);
      chk("low_noise", {9'h0, ln, fr}, 11'h3);
      rd_chk("burst_rd", ASM_ADDR_DATA_FIRST, 8'h00);
      chk("skip1", 11'(burst), 11'h003);
      rd_chk("burst_rd", 8'h05, 8'h00);
      chk("skip5", 11'(burst), 11'h007);
      wr_reg(ASM_ADDR_CTRL1, 8'h00);
      rd_chk("burst_rd", ASM_ADDR_DATA_FIRST, 8'h00);
      chk("noskip", 11'(burst), 11'h002);
      // Count zero would sleep at once if auto-sleep leaked through
      wr_reg(ASM_ADDR_INACT, 8'h00);
      wr_reg(ASM_ADDR_CTRL2, 8'h11);
      wr_reg(ASM_ADDR_CTRL1, 8'h01);
      tick(40);
      chk("no_sleep", 11'(mode), 11'(ASM_WAKE));
      c = srst_cnt;
      d = drst_cnt;
      wr_reg(ASM_ADDR_CTRL2, 8'h51);
      wr_reg(ASM_ADDR_INACT, 8'h55);
      tick(8);
      chk("serial_rst", 11'(srst_cnt - c), 11'h1);
      chk("boot_len", 11'(drst_cnt - d), 11'(ASM_BOOT_CYCLES));
      chk("soft_stby", 11'(mode), 11'(ASM_STANDBY));
      rd_chk("inact_sr", ASM_ADDR_INACT, 8'h00);
      rd_chk("ctrl1_sr", ASM_ADDR_CTRL1, 8'h00);
      rd_chk("ctrl2_sr", ASM_ADDR_CTRL2, 8'h00);
      chk("sc_off", 11'(sc), 11'h0);
      close_out();
   end
endmodule
